// file: inc/adc_ctrl_pkg.sv
// Shared constants and types for the converter control block.
package adc_ctrl_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] PORT_A_DATA_ADDR = 8'h05;
    localparam logic [7:0] INTERRUPT_CONTROL_ADDR = 8'h0b;
    localparam logic [7:0] PERIPH_FLAGS_ADDR = 8'h0c;
    localparam logic [7:0] RESULT_ADDR = 8'h1e;
    localparam logic [7:0] CONTROL_ADDR = 8'h1f;
    localparam logic [7:0] DIRECTION_ADDR = 8'h85;
    localparam logic [7:0] PERIPH_ENABLES_ADDR = 8'h8c;
    localparam logic [7:0] PIN_CONFIG_ADDR = 8'h9f;

    // ==========================================================
    // Field positions
    localparam int CLK_SEL_HI = 7;
    localparam int CLK_SEL_LO = 6;
    localparam int CHAN_HI = 5;
    localparam int CHAN_LO = 3;
    localparam int GO_BIT = 2;
    localparam int ON_BIT = 0;
    localparam int DONE_FLAG_BIT = 6;
    localparam int DONE_ENABLE_BIT = 6;

    // ==========================================================
    // Reset values and write masks
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'hfd;
    localparam logic [2:0] PIN_CONFIG_RESET = 3'h0;
    localparam logic [5:0] DIRECTION_RESET = 6'h3f;
    localparam logic [5:0] LATCH_RESET = 6'h00;
    localparam logic [7:0] ENABLES_RESET = 8'h00;
    localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;

    // ==========================================================
    // Conversion timing
    typedef enum logic [1:0] {
        CLK_SEL_2 = 2'h0,
        CLK_SEL_8 = 2'h1,
        CLK_SEL_32 = 2'h2,
        CLK_SEL_RC = 2'h3
    } clk_sel_t;
    localparam int SYS_PERIOD_NS = 8;
    localparam int RC_TAD_NS = 4000;
    // Half bit periods in system cycles; one oscillator period is one cycle.
    localparam logic [7:0] HALF_2 = 8'h01;
    localparam logic [7:0] HALF_8 = 8'h04;
    localparam logic [7:0] HALF_32 = 8'h10;
    localparam logic [7:0] HALF_RC = 8'(RC_TAD_NS / (2 * SYS_PERIOD_NS));
    // Nine and a half bit periods counted in half periods.
    localparam logic [4:0] CONV_HALVES = 5'h13;
    localparam logic [3:0] COMPARE_TRIGGER_MODE = 4'hb;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CONV = 2'h1,
        ST_DONE = 2'h3
    } conv_state_t;

    // Pins of port A that each pin configuration makes analogue.
    function automatic logic [5:0] analog_pins(input logic [2:0] cfg);
        case (cfg)
            3'h0, 3'h1: analog_pins = 6'h2f;
            3'h2, 3'h3: analog_pins = 6'h0f;
            3'h4, 3'h5: analog_pins = 6'h0b;
            default: analog_pins = 6'h00;
        endcase
    endfunction : analog_pins

endpackage : adc_ctrl_pkg

// file: inc/conv_tick_if.sv
// Link between the conversion sequencer and its bit period divider.
`timescale 1ns/10ps
`default_nettype none
interface conv_tick_if;
    logic [1:0] clock_select;
    logic run;
    logic half_tick;
    modport gen (input clock_select, input run, output half_tick);
    modport ctl (output clock_select, output run, input half_tick);
endinterface : conv_tick_if
`default_nettype wire

// file: logic/conv_clock_gen.sv
// Bit period divider producing half bit period enable pulses.
`timescale 1ns/10ps
`default_nettype none
module conv_clock_gen (
    input wire logic sys_clk,
    input wire logic rstn,
    conv_tick_if.gen tick
);

    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic tick_reg;
    logic tick_next;
    logic [7:0] half_len;

    // ==========================================================
    // Divider
    // The RC source is modelled as a fixed divide of the system clock,
    // so its period is the typical value, not a free running oscillator.
    always_comb begin
        case (tick.clock_select)
            adc_ctrl_pkg::CLK_SEL_2: half_len = adc_ctrl_pkg::HALF_2;
            adc_ctrl_pkg::CLK_SEL_8: half_len = adc_ctrl_pkg::HALF_8;
            adc_ctrl_pkg::CLK_SEL_32: half_len = adc_ctrl_pkg::HALF_32;
            default: half_len = adc_ctrl_pkg::HALF_RC;
        endcase
        cnt_next = 8'h00;
        tick_next = 1'b0;
        if (tick.run) begin
            if (cnt_reg == half_len - 8'h01) begin
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 8'h01;
            end
        end
    end

    // Registers only.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick.half_tick = tick_reg;

    // ==========================================================
    // Checks
    sequence s_hold8;
        tick.half_tick && tick.run &&
            tick.clock_select == adc_ctrl_pkg::CLK_SEL_8
        ##1 (tick.run && tick.clock_select == adc_ctrl_pkg::CLK_SEL_8)[*4];
    endsequence
    property p_sel8_spacing;
        @(posedge sys_clk) disable iff (!rstn)
        s_hold8 |-> tick.half_tick && !$past(tick.half_tick)
            && !$past(tick.half_tick, 3);
    endproperty
    a_sel8_spacing: assert property (p_sel8_spacing)
        else $error("half tick spacing wrong for divide by eight");

endmodule : conv_clock_gen
`default_nettype wire

// file: logic/adc_conversion_control.sv
// Control logic of an 8-bit successive approximation converter.
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_control (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic special_event,
    input wire logic [3:0] compare_unit_mode,
    output logic timer1_clear,
    input wire logic [7:0] conv_value,
    output logic [2:0] input_channel_select,
    input wire logic [5:0] port_a_pins,
    output logic [5:0] port_a_out,
    output logic [5:0] port_a_oe
);

    conv_tick_if tick ();

    conv_clock_gen clock_gen (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tick(tick)
    );

    // ==========================================================
    // Input synchronisers
    // Pins and the analogue core are outside this clock domain.
    logic [5:0] pin_meta_reg;
    logic [5:0] pin_sync_reg;
    logic [7:0] value_meta_reg;
    logic [7:0] value_sync_reg;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_reg <= 6'h00;
            pin_sync_reg <= 6'h00;
            value_meta_reg <= 8'h00;
            value_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg <= port_a_pins;
            pin_sync_reg <= pin_meta_reg;
            value_meta_reg <= conv_value;
            value_sync_reg <= value_meta_reg;
        end
    end

    // ==========================================================
    // State and registers
    adc_ctrl_pkg::conv_state_t state_reg;
    adc_ctrl_pkg::conv_state_t state_next;
    logic [4:0] halves_reg;
    logic [4:0] halves_next;
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic [2:0] pcfg_reg;
    logic [2:0] pcfg_next;
    logic [5:0] dir_reg;
    logic [5:0] dir_next;
    logic [5:0] lat_reg;
    logic [5:0] lat_next;
    logic [7:0] interrupt_control_reg;
    logic [7:0] interrupt_control_next;
    logic [7:0] en_reg;
    logic [7:0] en_next;
    logic flag_reg;
    logic flag_next;
    logic irq_reg;
    logic irq_next;
    logic t1clr_reg;
    logic t1clr_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [5:0] oe_reg;
    logic [5:0] oe_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic trig_hit;

    assign tick.clock_select = ctl_reg[adc_ctrl_pkg::CLK_SEL_HI:
                                       adc_ctrl_pkg::CLK_SEL_LO];
    assign tick.run = (state_reg == adc_ctrl_pkg::ST_CONV);
    assign trig_hit = special_event &&
        (compare_unit_mode == adc_ctrl_pkg::COMPARE_TRIGGER_MODE);

    // Next values for the sequencer, registers and bus answer.
    always_comb begin
        ctl_next = ctl_reg;
        pcfg_next = pcfg_reg;
        dir_next = dir_reg;
        lat_next = lat_reg;
        interrupt_control_next = interrupt_control_reg;
        en_next = en_reg;
        flag_next = flag_reg;
        result_next = result_reg;
        state_next = state_reg;
        halves_next = halves_reg;
        rdata_next = 8'h00;
        if (wr) begin
            case (addr)
                adc_ctrl_pkg::CONTROL_ADDR:
                    ctl_next = wdata &
                        adc_ctrl_pkg::CONTROL_WRITE_MASK;
                adc_ctrl_pkg::PIN_CONFIG_ADDR: pcfg_next = wdata[2:0];
                adc_ctrl_pkg::DIRECTION_ADDR: dir_next = wdata[5:0];
                adc_ctrl_pkg::PORT_A_DATA_ADDR: lat_next = wdata[5:0];
                adc_ctrl_pkg::INTERRUPT_CONTROL_ADDR: interrupt_control_next = wdata;
                adc_ctrl_pkg::PERIPH_ENABLES_ADDR: en_next = wdata;
                adc_ctrl_pkg::RESULT_ADDR: result_next = wdata;
                adc_ctrl_pkg::PERIPH_FLAGS_ADDR: begin
                    if (wdata[adc_ctrl_pkg::DONE_FLAG_BIT]) begin
                        flag_next = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // The trigger is ignored for the start bit while the converter is
        // off; Timer1 is cleared either way below.
        if (trig_hit && ctl_next[adc_ctrl_pkg::ON_BIT]) begin
            ctl_next[adc_ctrl_pkg::GO_BIT] = 1'b1;
        end
        // Start does not look at channel or direction bits.
        case (state_reg)
            adc_ctrl_pkg::ST_IDLE: begin
                halves_next = 5'h00;
                if (ctl_reg[adc_ctrl_pkg::GO_BIT] &&
                    ctl_reg[adc_ctrl_pkg::ON_BIT]) begin
                    state_next = adc_ctrl_pkg::ST_CONV;
                end
            end
            adc_ctrl_pkg::ST_CONV: begin
                if (!ctl_next[adc_ctrl_pkg::GO_BIT] ||
                    !ctl_next[adc_ctrl_pkg::ON_BIT]) begin
                    state_next = adc_ctrl_pkg::ST_IDLE;
                end else if (tick.half_tick) begin
                    halves_next = halves_reg + 5'h01;
                    if (halves_next == adc_ctrl_pkg::CONV_HALVES) begin
                        state_next = adc_ctrl_pkg::ST_DONE;
                    end
                end
            end
            adc_ctrl_pkg::ST_DONE: begin
                result_next = value_sync_reg;
                ctl_next[adc_ctrl_pkg::GO_BIT] = 1'b0;
                flag_next = 1'b1;
                state_next = adc_ctrl_pkg::ST_IDLE;
            end
            default: state_next = adc_ctrl_pkg::ST_IDLE;
        endcase
        // Turning the converter off abandons any start request.
        if (!ctl_next[adc_ctrl_pkg::ON_BIT]) begin
            ctl_next[adc_ctrl_pkg::GO_BIT] = 1'b0;
        end
        t1clr_next = trig_hit;
        irq_next = flag_next &&
            en_next[adc_ctrl_pkg::DONE_ENABLE_BIT];
        oe_next = ~dir_next;
        if (rd) begin
            case (addr)
                adc_ctrl_pkg::PORT_A_DATA_ADDR: rdata_next = {2'h0,
                    pin_sync_reg &
                    ~adc_ctrl_pkg::analog_pins(pcfg_reg)};
                adc_ctrl_pkg::CONTROL_ADDR: rdata_next = ctl_reg;
                adc_ctrl_pkg::PIN_CONFIG_ADDR: rdata_next = {5'h00, pcfg_reg};
                adc_ctrl_pkg::DIRECTION_ADDR: rdata_next = {2'h0, dir_reg};
                adc_ctrl_pkg::INTERRUPT_CONTROL_ADDR: rdata_next = interrupt_control_reg;
                adc_ctrl_pkg::PERIPH_ENABLES_ADDR: rdata_next = en_reg;
                adc_ctrl_pkg::RESULT_ADDR: rdata_next = result_reg;
                adc_ctrl_pkg::PERIPH_FLAGS_ADDR:
                    rdata_next = {1'b0, flag_reg, 6'h00};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Control registers load their reset values on every reset; direction resets to all ones.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= adc_ctrl_pkg::ST_IDLE;
            halves_reg <= 5'h00;
            ctl_reg <= adc_ctrl_pkg::CONTROL_RESET;
            pcfg_reg <= adc_ctrl_pkg::PIN_CONFIG_RESET;
            dir_reg <= adc_ctrl_pkg::DIRECTION_RESET;
            lat_reg <= adc_ctrl_pkg::LATCH_RESET;
            interrupt_control_reg <= adc_ctrl_pkg::INTERRUPT_CONTROL_RESET;
            en_reg <= adc_ctrl_pkg::ENABLES_RESET;
            flag_reg <= 1'b0;
            irq_reg <= 1'b0;
            t1clr_reg <= 1'b0;
            rdata_reg <= 8'h00;
            oe_reg <= 6'h00;
        end else begin
            state_reg <= state_next;
            halves_reg <= halves_next;
            ctl_reg <= ctl_next;
            pcfg_reg <= pcfg_next;
            dir_reg <= dir_next;
            lat_reg <= lat_next;
            interrupt_control_reg <= interrupt_control_next;
            en_reg <= en_next;
            flag_reg <= flag_next;
            irq_reg <= irq_next;
            t1clr_reg <= t1clr_next;
            rdata_reg <= rdata_next;
            oe_reg <= oe_next;
        end
    end

    // The result has no reset so it survives every reset and powers up
    // unknown; a reader must not trust it before the first conversion.
    always_ff @(posedge sys_clk) begin
        result_reg <= result_next;
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;
    assign timer1_clear = t1clr_reg;
    assign input_channel_select = ctl_reg[adc_ctrl_pkg::CHAN_HI:
                                          adc_ctrl_pkg::CHAN_LO];
    assign port_a_out = lat_reg;
    assign port_a_oe = oe_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic [15:0] conv_cycles_reg;
    logic [15:0] expect_cycles;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            conv_cycles_reg <= 16'h0000;
        end else if (state_reg == adc_ctrl_pkg::ST_CONV) begin
            conv_cycles_reg <= conv_cycles_reg + 16'h0001;
        end else begin
            conv_cycles_reg <= 16'h0000;
        end
    end
    always_comb begin
        case (tick.clock_select)
            adc_ctrl_pkg::CLK_SEL_2: expect_cycles = 16'h0014;
            adc_ctrl_pkg::CLK_SEL_8: expect_cycles = 16'h004d;
            adc_ctrl_pkg::CLK_SEL_32: expect_cycles = 16'h0131;
            default: expect_cycles = 16'h0000;
        endcase
    end

    property p_conv_length;
        state_reg == adc_ctrl_pkg::ST_DONE &&
            tick.clock_select != adc_ctrl_pkg::CLK_SEL_RC
        |-> conv_cycles_reg == expect_cycles;
    endproperty
    a_conv_length: assert property (p_conv_length)
        else $error("conversion length is not nine and a half periods");

    property p_port_analog_zero;
        rd && addr == adc_ctrl_pkg::PORT_A_DATA_ADDR
        |=> (rdata[5:0] & adc_ctrl_pkg::analog_pins($past(pcfg_reg))) == 6'h00;
    endproperty
    a_port_analog_zero: assert property (p_port_analog_zero)
        else $error("analogue pin read back non-zero");

    property p_start_any_channel;
        state_reg == adc_ctrl_pkg::ST_IDLE && ctl_reg[adc_ctrl_pkg::GO_BIT]
            && ctl_reg[adc_ctrl_pkg::ON_BIT]
        |=> state_reg == adc_ctrl_pkg::ST_CONV;
    endproperty
    a_start_any_channel: assert property (p_start_any_channel)
        else $error("conversion did not start");

    sequence s_trigger_on;
        trig_hit && ctl_reg[adc_ctrl_pkg::ON_BIT] && !wr;
    endsequence
    property p_trigger_on;
        s_trigger_on |=> timer1_clear && ctl_reg[adc_ctrl_pkg::GO_BIT];
    endproperty
    a_trigger_on: assert property (p_trigger_on)
        else $error("trigger did not start a conversion");

    property p_trigger_off;
        trig_hit && !ctl_reg[adc_ctrl_pkg::ON_BIT] && !wr
        |=> timer1_clear && !ctl_reg[adc_ctrl_pkg::GO_BIT];
    endproperty
    a_trigger_off: assert property (p_trigger_off)
        else $error("trigger with converter off misbehaved");

    property p_ctl_bit1;
        rd && addr == adc_ctrl_pkg::CONTROL_ADDR |=> rdata[1] == 1'b0;
    endproperty
    a_ctl_bit1: assert property (p_ctl_bit1)
        else $error("unimplemented control bit read as one");

    property p_completion;
        state_reg == adc_ctrl_pkg::ST_DONE
        |=> !ctl_reg[adc_ctrl_pkg::GO_BIT] && flag_reg
            && result_reg == $past(value_sync_reg);
    endproperty
    a_completion: assert property (p_completion)
        else $error("completion did not store result and flag");

    property p_irq;
        irq == (flag_reg && en_reg[adc_ctrl_pkg::DONE_ENABLE_BIT]);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output disagrees with flag and enable");

endmodule : adc_conversion_control
`default_nettype wire

// file: logic/unused_placeholder_removed.sv
// Intentionally empty file holder.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: verification/analog_source.sv
// Model of the analogue pins and the compare unit trigger source.
`timescale 1ns/10ps
`default_nettype none
module analog_source (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic fire,
    input wire logic [7:0] sample,
    input wire logic [5:0] level,
    input wire logic [5:0] port_a_out,
    input wire logic [5:0] port_a_oe,
    output logic special_event,
    output logic [7:0] conv_value,
    output logic [5:0] port_a_pins
);
    // ==========================================================
    // Trigger source
    // The trigger is a one-cycle pulse launched from the clock edge.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            special_event <= 1'b0;
        end else begin
            special_event <= fire;
        end
    end

    // ==========================================================
    // Analogue side
    // The sample is held steady for the whole conversion.
    assign conv_value = sample;
    // A pin left as output shows its own driven level.
    assign port_a_pins = (port_a_oe & port_a_out) | (~port_a_oe & level);
endmodule : analog_source
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic sys_clk, rstn, wr, rd, fire, irq, timer1_clear, special_event;
    logic [7:0] addr, wdata, rdata, sample, conv_value, v;
    logic [3:0] compare_unit_mode;
    logic [2:0] input_channel_select;
    logic [5:0] level, port_a_pins, port_a_out, port_a_oe;
    logic [15:0] n;
    int errors = 0;
    int comparisons = 0;

    adc_conversion_control adc_conversion_control_inst (
        .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .special_event(special_event), .compare_unit_mode(compare_unit_mode),
        .timer1_clear(timer1_clear), .conv_value(conv_value),
        .input_channel_select(input_channel_select),
        .port_a_pins(port_a_pins), .port_a_out(port_a_out),
        .port_a_oe(port_a_oe));
    analog_source analog_source_inst (
        .sys_clk(sys_clk), .rstn(rstn), .fire(fire), .sample(sample),
        .level(level), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
        .special_event(special_event), .conv_value(conv_value),
        .port_a_pins(port_a_pins));

    // ==========================================================
    // Clock and shared tasks
    // The clock toggles each half period of 4 ns.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen,
                exp);
            errors++;
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // Bounded wait so a stuck conversion cannot hang the run.
    task automatic wait_irq();
        n = 16'h0000;
        while (irq !== 1'b1 && n < 16'h1800) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask : wait_irq

    // The mode is set on the same edge as the request, and the Timer1
    // clear must last exactly one cycle.
    task automatic pulse_trigger(input logic [3:0] mode, input logic exp);
        @(posedge sys_clk);
        compare_unit_mode <= mode;
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        @(posedge sys_clk);
        #1 check(16'(timer1_clear), 16'(exp));
        @(posedge sys_clk);
        #1 check(16'(timer1_clear), 16'h0000);
    endtask : pulse_trigger

    // ==========================================================
    // Scenarios
    // Enable and start go in separate writes, with acquisition between.
    task automatic run_conv(input logic [1:0] sel, input logic [2:0] chan,
                            input logic [15:0] half, input logic [7:0] s);
        sample <= s;
        wr_reg(adc_ctrl_pkg::PERIPH_ENABLES_ADDR, 8'h40);
        wr_reg(adc_ctrl_pkg::CONTROL_ADDR, {sel, chan, 3'h1});
        repeat (4) @(posedge sys_clk);
        wr_reg(adc_ctrl_pkg::CONTROL_ADDR, {sel, chan, 3'h5});
        wait_irq();
        check(n, 16'(19 * half + 3));
        check(16'(input_channel_select), 16'(chan));
        rd_reg(adc_ctrl_pkg::RESULT_ADDR, v);
        check(16'(v), 16'(s));
        rd_reg(adc_ctrl_pkg::CONTROL_ADDR, v);
        check(16'(v), 16'({sel, chan, 3'h1}));
        rd_reg(adc_ctrl_pkg::PERIPH_FLAGS_ADDR, v);
        check(16'(v[6]), 16'h0001);
        wr_reg(adc_ctrl_pkg::PERIPH_FLAGS_ADDR, 8'h40);
        #1 check(16'(irq), 16'h0000);
    endtask : run_conv

    // Trigger with the converter on and then off, the interrupt masked.
    task automatic trigger_cases();
        wr_reg(adc_ctrl_pkg::PERIPH_ENABLES_ADDR, 8'h00);
        wr_reg(adc_ctrl_pkg::CONTROL_ADDR, 8'h01);
        pulse_trigger(adc_ctrl_pkg::COMPARE_TRIGGER_MODE, 1'b1);
        rd_reg(adc_ctrl_pkg::CONTROL_ADDR, v);
        check(16'(v), 16'h0005);
        repeat (40) @(posedge sys_clk);
        #1 check(16'(irq), 16'h0000);
        rd_reg(adc_ctrl_pkg::PERIPH_FLAGS_ADDR, v);
        check(16'(v), 16'h0040);
        wr_reg(adc_ctrl_pkg::PERIPH_FLAGS_ADDR, 8'h40);
        wr_reg(adc_ctrl_pkg::CONTROL_ADDR, 8'h00);
        pulse_trigger(adc_ctrl_pkg::COMPARE_TRIGGER_MODE, 1'b1);
        rd_reg(adc_ctrl_pkg::CONTROL_ADDR, v);
        check(16'(v), 16'h0000);
        // Any other compare mode neither starts nor clears anything.
        wr_reg(adc_ctrl_pkg::CONTROL_ADDR, 8'h01);
        pulse_trigger(4'h0, 1'b0);
        rd_reg(adc_ctrl_pkg::CONTROL_ADDR, v);
        check(16'(v), 16'h0001);
    endtask : trigger_cases

    // Analogue pins read as zero for pin configurations 0, 2, 4 and 6.
    task automatic port_reads();
        logic [5:0] masks[4];
        masks = '{6'h2f, 6'h0f, 6'h0b, 6'h00};
        level <= 6'h3f;
        wr_reg(adc_ctrl_pkg::DIRECTION_ADDR, 8'h3f);
        for (int i = 0; i < 4; i++) begin
            wr_reg(adc_ctrl_pkg::PIN_CONFIG_ADDR, 8'(2 * i));
            repeat (3) @(posedge sys_clk);
            rd_reg(adc_ctrl_pkg::PORT_A_DATA_ADDR, v);
            check(16'(v), 16'({2'h0, ~masks[i]}));
        end
        // A pin set as output reads back the level that it drives.
        wr_reg(adc_ctrl_pkg::PORT_A_DATA_ADDR, 8'h2a);
        wr_reg(adc_ctrl_pkg::DIRECTION_ADDR, 8'h0f);
        #1 check(16'({port_a_out, port_a_oe}), 16'h0ab0);
        repeat (3) @(posedge sys_clk);
        rd_reg(adc_ctrl_pkg::PORT_A_DATA_ADDR, v);
        check(16'(v), 16'h002f);
    endtask : port_reads

    // Reset values of the registers and an unmapped address.
    task automatic reset_values();
        rd_reg(adc_ctrl_pkg::CONTROL_ADDR, v);
        check(16'(v), 16'h0000);
        check(16'({port_a_out, port_a_oe}), 16'h0000);
        rd_reg(adc_ctrl_pkg::DIRECTION_ADDR, v);
        check(16'(v), 16'h003f);
        rd_reg(adc_ctrl_pkg::PIN_CONFIG_ADDR, v);
        check(16'(v), 16'h0000);
        rd_reg(adc_ctrl_pkg::PERIPH_FLAGS_ADDR, v);
        check(16'(v), 16'h0000);
        rd_reg(8'h40, v);
        check(16'(v), 16'h0000);
    endtask : reset_values

    // ==========================================================
    // Main sequence and watchdog
    task automatic summarize();
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    // The longest scenario is one slow conversion of under 5000 cycles.
    initial begin
        repeat (40000) @(posedge sys_clk);
        errors++;
        summarize();
    end

    initial begin
        rstn = 1'b0;
        {wr, rd, fire} = 3'h0;
        {addr, wdata, sample} = 24'h000000;
        compare_unit_mode = 4'h0;
        level = 6'h00;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        reset_values();
        wr_reg(adc_ctrl_pkg::CONTROL_ADDR, 8'hfb);
        rd_reg(adc_ctrl_pkg::CONTROL_ADDR, v);
        check(16'(v), 16'h00f9);
        run_conv(2'h0, 3'h5, 16'h0001, 8'ha5);
        wr_reg(adc_ctrl_pkg::DIRECTION_ADDR, 8'h00);
        run_conv(2'h1, 3'h2, 16'h0004, 8'h3c);
        run_conv(2'h2, 3'h7, 16'h0010, 8'h81);
        run_conv(2'h3, 3'h0, 16'h00fa, 8'h5e);
        trigger_cases();
        port_reads();
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        rd_reg(adc_ctrl_pkg::RESULT_ADDR, v);
        check(16'(v), 16'h005e);
        reset_values();
        summarize();
    end
endmodule : testbench
`default_nettype wire
